//--- ocd_consts.svh
// register offsets, field positions and reset values for the over-current control bank
`ifndef OCD_CONSTS_SVH
`define OCD_CONSTS_SVH

`define OCD_ADDR_MODE       4'h0
`define OCD_ADDR_THRESH     4'h1
`define OCD_ADDR_CAL        4'h2
`define OCD_ADDR_CMP        4'h3
`define OCD_ADDR_IRQ_STAT   4'h4
`define OCD_ADDR_IRQ_MASK   4'h5

`define OCD_MODE_RST        8'hc2
`define OCD_THRESH_RST      8'h00
`define OCD_CAL_RST         8'h10
`define OCD_CMP_RST         8'hf0

`define OCD_MODE_WMASK      8'he7
`define OCD_CAL_WMASK       8'hdf

`define OCD_EDGE_OFF        2'h0
`define OCD_EDGE_RISE       2'h1
`define OCD_EDGE_FALL       2'h2
`define OCD_EDGE_BOTH       2'h3

`define OCD_GAIN_OFF        3'h0
`define OCD_GAIN_X5         3'h1
`define OCD_GAIN_X10        3'h2
`define OCD_GAIN_X20        3'h3
`define OCD_GAIN_X1         3'h7

`define OCD_IRQ_EDGE_BIT    0
`define OCD_IRQ_PROT_BIT    1
`define OCD_IRQ_WIDTH       2
`define OCD_IRQ_RST         2'h0

`endif

//--- ocd_pkg.sv
// types shared by the over-current control bank
package ocd_pkg;

    typedef struct packed {
        logic [1:0] zero_comparator_edge_sel;
        logic       comparator_one_pos_source;
        logic [1:0] unused_zero;
        logic [2:0] amp_gain_sel;
    } mode_reg_type;

    typedef struct packed {
        logic       cal_reference_sel;
        logic       offset_cal_mode;
        logic       unused_zero;
        logic [4:0] amp_offset_trim;
    } cal_reg_type;

    typedef struct packed {
        logic [3:0] comparator_hysteresis_on;
        logic [3:0] comparator_on;
    } cmp_reg_type;

    typedef struct packed {
        logic [2:0] amp_gain_sel;
        logic       amp_enable;
        logic       offset_cal_mode;
        logic       cal_reference_sel;
        logic [4:0] amp_offset_trim;
    } amp_ctrl_type;

    typedef struct packed {
        logic       dac_enable;
        logic [7:0] threshold_code;
    } dac_ctrl_type;

endpackage : ocd_pkg

//--- ocd_sync.sv
// two-flop synchroniser for the comparator 0 output
`timescale 1ns/1ps
`include "ocd_consts.svh"

module ocd_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule : ocd_sync

//--- ocd_edge_detect.sv
// selectable edge detector on the synchronised comparator 0 output
`timescale 1ns/1ps
`include "ocd_consts.svh"

module ocd_edge_detect (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // control
    input  wire logic [1:0] edge_sel,
    input  wire logic       level_in,
    // events
    output logic            edge_hit,
    output logic            prot_hit
);

    logic prev_r;
    logic prev_nxt;
    logic rise;
    logic fall;

    always_comb begin
        prev_nxt = level_in;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    assign rise = level_in & ~prev_r;
    assign fall = ~level_in & prev_r;

    always_comb begin
        edge_hit = 1'b0;
        prot_hit = 1'b0;
        case (edge_sel)
            `OCD_EDGE_RISE: begin
                edge_hit = rise;
                prot_hit = rise;
            end
            `OCD_EDGE_FALL: begin
                edge_hit = fall;
                prot_hit = fall;
            end
            `OCD_EDGE_BOTH: begin
                edge_hit = rise | fall;
                prot_hit = 1'b0;
            end
            default: begin
                edge_hit = 1'b0;
                prot_hit = 1'b0;
            end
        endcase
    end

endmodule : ocd_edge_detect

//--- overcurrent_detect_ctrl.sv
// over-current detection control register bank with comparator 0 event logic
//
// Overview of operation
// - edge field 00 turns off comparator 0 and the DAC; 01 rising, 10 falling, 11 both edges.
// - with edge field 11 each edge still interrupts but never acts as protection trigger.
// - comparator 1 positive source is its own pin at 0 and the sense amp output at 1.
// - mode bits 4..3 and calibration bit 5 ignore writes and read zero.
// - threshold register is an 8-bit read/write code reset to zero driving the DAC.
// - the DAC is on whenever the edge field is non-zero.
// - calibration reference selects inverting input at 0, non-inverting at 1.
// - calibration mode bit selects normal operation at 0, offset calibration at 1.
// - five-bit offset trim spans minimum 00000, centre 10000, maximum 11111, resets to centre.
// - the bank holds four 8-bit registers: mode, threshold, calibration, comparator control.
// - each comparator is off when its enable bit is low and has hysteresis when set.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "ocd_consts.svh"

module overcurrent_detect_ctrl (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                sys_rst,
    // register port
    input  wire logic [3:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    // analog comparator 0 output
    input  wire logic                zero_comparator_out,
    // analog controls
    output ocd_pkg::amp_ctrl_type    amp_ctrl,
    output ocd_pkg::dac_ctrl_type    dac_ctrl,
    output logic                     comparator_one_pos_source,
    output logic      [3:0]          comparator_on,
    output logic      [3:0]          comparator_hysteresis_on,
    // events
    output logic                     prot_trigger,
    output logic                     irq
);

    // ========================================================================
    // register state
    // ========================================================================
    ocd_pkg::mode_reg_type mode_r;
    ocd_pkg::mode_reg_type mode_nxt;
    logic [7:0]            thresh_r;
    logic [7:0]            thresh_nxt;
    ocd_pkg::cal_reg_type  cal_r;
    ocd_pkg::cal_reg_type  cal_nxt;
    ocd_pkg::cmp_reg_type  cmp_r;
    ocd_pkg::cmp_reg_type  cmp_nxt;
    logic [1:0]            stat_r;
    logic [1:0]            stat_nxt;
    logic [1:0]            mask_r;
    logic [1:0]            mask_nxt;
    logic [7:0]            rdata_r;
    logic [7:0]            rdata_nxt;
    logic                  prot_r;
    logic                  prot_nxt;

    logic                  cmp0_sync;
    logic                  edge_hit;
    logic                  prot_hit;
    logic [1:0]            events;

    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target);
        wr_hit = (a == target);
    endfunction : wr_hit

    // ========================================================================
    // comparator 0 event path
    // ========================================================================
    ocd_sync u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (zero_comparator_out),
        .sync_out (cmp0_sync)
    );

    ocd_edge_detect u_edge (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .edge_sel (mode_r.zero_comparator_edge_sel),
        .level_in (cmp0_sync),
        .edge_hit (edge_hit),
        .prot_hit (prot_hit)
    );

    assign events = {prot_hit, edge_hit};

    // ========================================================================
    // register writes
    // ========================================================================
    always_comb begin
        mode_nxt   = mode_r;
        thresh_nxt = thresh_r;
        cal_nxt    = cal_r;
        cmp_nxt    = cmp_r;
        mask_nxt   = mask_r;
        stat_nxt   = stat_r;
        if (reg_wr) begin
            if (wr_hit(reg_addr, `OCD_ADDR_MODE)) begin
                mode_nxt = reg_wdata & `OCD_MODE_WMASK;
            end
            if (wr_hit(reg_addr, `OCD_ADDR_THRESH)) begin
                thresh_nxt = reg_wdata;
            end
            if (wr_hit(reg_addr, `OCD_ADDR_CAL)) begin
                cal_nxt = reg_wdata & `OCD_CAL_WMASK;
            end
            if (wr_hit(reg_addr, `OCD_ADDR_CMP)) begin
                cmp_nxt = reg_wdata;
            end
            if (wr_hit(reg_addr, `OCD_ADDR_IRQ_MASK)) begin
                mask_nxt = reg_wdata[`OCD_IRQ_WIDTH-1:0];
            end
            if (wr_hit(reg_addr, `OCD_ADDR_IRQ_STAT)) begin
                stat_nxt = stat_r & ~reg_wdata[`OCD_IRQ_WIDTH-1:0];
            end
        end
        // set wins over a same-cycle clear
        stat_nxt = stat_nxt | events;
        prot_nxt = prot_hit;
    end

    // ========================================================================
    // register reads
    // ========================================================================
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `OCD_ADDR_MODE:     rdata_nxt = mode_r & `OCD_MODE_WMASK;
                `OCD_ADDR_THRESH:   rdata_nxt = thresh_r;
                `OCD_ADDR_CAL:      rdata_nxt = cal_r & `OCD_CAL_WMASK;
                `OCD_ADDR_CMP:      rdata_nxt = cmp_r;
                `OCD_ADDR_IRQ_STAT: rdata_nxt = {6'h00, stat_r};
                `OCD_ADDR_IRQ_MASK: rdata_nxt = {6'h00, mask_r};
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r   <= `OCD_MODE_RST;
            thresh_r <= `OCD_THRESH_RST;
            cal_r    <= `OCD_CAL_RST;
            cmp_r    <= `OCD_CMP_RST;
            stat_r   <= `OCD_IRQ_RST;
            mask_r   <= `OCD_IRQ_RST;
            rdata_r  <= 8'h00;
            prot_r   <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            thresh_r <= thresh_nxt;
            cal_r    <= cal_nxt;
            cmp_r    <= cmp_nxt;
            stat_r   <= stat_nxt;
            mask_r   <= mask_nxt;
            rdata_r  <= rdata_nxt;
            prot_r   <= prot_nxt;
        end
    end

    // ========================================================================
    // analog control outputs
    // ========================================================================
    always_comb begin
        dac_ctrl.dac_enable     = (mode_r.zero_comparator_edge_sel != `OCD_EDGE_OFF);
        dac_ctrl.threshold_code = thresh_r;
        amp_ctrl.amp_gain_sel   = mode_r.amp_gain_sel;
        amp_ctrl.amp_enable     = (mode_r.amp_gain_sel != `OCD_GAIN_OFF);
        amp_ctrl.offset_cal_mode   = cal_r.offset_cal_mode;
        amp_ctrl.cal_reference_sel = cal_r.cal_reference_sel;
        amp_ctrl.amp_offset_trim   = cal_r.amp_offset_trim;
        comparator_one_pos_source  = mode_r.comparator_one_pos_source;
        comparator_hysteresis_on   = cmp_r.comparator_hysteresis_on;
        // comparator 0 also needs a live edge field
        comparator_on = {cmp_r.comparator_on[3:1],
                         cmp_r.comparator_on[0]
                         & (mode_r.zero_comparator_edge_sel != `OCD_EDGE_OFF)};
    end

    assign reg_rdata    = rdata_r;
    assign prot_trigger = prot_r;
    assign irq          = |(stat_r & mask_r);

    // ========================================================================
    // checks
    // ========================================================================
    property p_dac_follows_edge;
        @(posedge clock) disable iff (sys_rst)
        dac_ctrl.dac_enable == (mode_r.zero_comparator_edge_sel != `OCD_EDGE_OFF);
    endproperty
    a_dac_follows_edge: assert property (p_dac_follows_edge)
        else $error("dac enable does not follow edge field");

    property p_edge_off_no_event;
        @(posedge clock) disable iff (sys_rst)
        (mode_r.zero_comparator_edge_sel == `OCD_EDGE_OFF) |-> !edge_hit && !comparator_on[0];
    endproperty
    a_edge_off_no_event: assert property (p_edge_off_no_event)
        else $error("comparator 0 active with edge field off");

    property p_dual_no_prot;
        @(posedge clock) disable iff (sys_rst)
        (mode_r.zero_comparator_edge_sel == `OCD_EDGE_BOTH) |=> !prot_trigger;
    endproperty
    a_dual_no_prot: assert property (p_dual_no_prot)
        else $error("protection trigger in dual edge mode");

    property p_rise_sets_flag;
        @(posedge clock) disable iff (sys_rst)
        (mode_r.zero_comparator_edge_sel == `OCD_EDGE_RISE) && cmp0_sync && !$past(cmp0_sync)
        |=> stat_r[0];
    endproperty
    a_rise_sets_flag: assert property (p_rise_sets_flag)
        else $error("rising edge did not set status");

    property p_mode_reserved_zero;
        @(posedge clock) disable iff (sys_rst)
        reg_rd && reg_addr == `OCD_ADDR_MODE |=> reg_rdata[4:3] == 2'h0;
    endproperty
    a_mode_reserved_zero: assert property (p_mode_reserved_zero)
        else $error("mode reserved bits read non-zero");

    property p_cal_reserved_zero;
        @(posedge clock) disable iff (sys_rst)
        reg_rd && reg_addr == `OCD_ADDR_CAL |=> reg_rdata[5] == 1'b0;
    endproperty
    a_cal_reserved_zero: assert property (p_cal_reserved_zero)
        else $error("calibration reserved bit reads non-zero");

    property p_thresh_write;
        @(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == `OCD_ADDR_THRESH |=> dac_ctrl.threshold_code == $past(reg_wdata);
    endproperty
    a_thresh_write: assert property (p_thresh_write)
        else $error("threshold write not applied");

    property p_amp_off;
        @(posedge clock) disable iff (sys_rst)
        amp_ctrl.amp_enable == (mode_r.amp_gain_sel != `OCD_GAIN_OFF);
    endproperty
    a_amp_off: assert property (p_amp_off)
        else $error("amp enable mismatched with gain field");

    property p_src_write;
        @(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == `OCD_ADDR_MODE |=> comparator_one_pos_source == $past(reg_wdata[5]);
    endproperty
    a_src_write: assert property (p_src_write)
        else $error("comparator 1 source not updated");

    property p_cal_write;
        @(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == `OCD_ADDR_CAL |=> amp_ctrl.offset_cal_mode == $past(reg_wdata[6])
            && amp_ctrl.cal_reference_sel == $past(reg_wdata[7])
            && amp_ctrl.amp_offset_trim == $past(reg_wdata[4:0]);
    endproperty
    a_cal_write: assert property (p_cal_write)
        else $error("calibration write not applied");

    property p_hyst_write;
        @(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == `OCD_ADDR_CMP |=> comparator_hysteresis_on == $past(reg_wdata[7:4]);
    endproperty
    a_hyst_write: assert property (p_hyst_write)
        else $error("hysteresis bits not updated");

    property p_fall_sets_flag;
        @(posedge clock) disable iff (sys_rst)
        (mode_r.zero_comparator_edge_sel == `OCD_EDGE_FALL) && !cmp0_sync && $past(cmp0_sync)
        |=> stat_r[`OCD_IRQ_EDGE_BIT] && stat_r[`OCD_IRQ_PROT_BIT] && prot_trigger;
    endproperty
    a_fall_sets_flag: assert property (p_fall_sets_flag)
        else $error("falling edge did not set status and trigger");

    property p_dual_sets_flag;
        @(posedge clock) disable iff (sys_rst)
        (mode_r.zero_comparator_edge_sel == `OCD_EDGE_BOTH) && (cmp0_sync != $past(cmp0_sync))
        |=> stat_r[`OCD_IRQ_EDGE_BIT];
    endproperty
    a_dual_sets_flag: assert property (p_dual_sets_flag)
        else $error("dual edge mode missed an edge");

    property p_prot_single_edge;
        @(posedge clock) disable iff (sys_rst)
        prot_trigger |-> $past(mode_r.zero_comparator_edge_sel) == `OCD_EDGE_RISE
            || $past(mode_r.zero_comparator_edge_sel) == `OCD_EDGE_FALL;
    endproperty
    a_prot_single_edge: assert property (p_prot_single_edge)
        else $error("protection trigger outside single edge mode");

    property p_rdata_idle;
        @(posedge clock) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data stands without a read");

    property p_stat_sticky;
        @(posedge clock) disable iff (sys_rst)
        stat_r[`OCD_IRQ_EDGE_BIT] && !(reg_wr && reg_addr == `OCD_ADDR_IRQ_STAT
            && reg_wdata[`OCD_IRQ_EDGE_BIT]) |=> stat_r[`OCD_IRQ_EDGE_BIT];
    endproperty
    a_stat_sticky: assert property (p_stat_sticky)
        else $error("edge status dropped without a clear");

endmodule : overcurrent_detect_ctrl

//--- overcurrent_detect_ctrl_bench.sv
// self-checking bench for the over-current detection control register bank
`timescale 1ns/1ps
`include "ocd_consts.svh"

module overcurrent_detect_ctrl_bench;

    // ==========================================
    // signals
    logic                  clock;
    logic                  sys_rst;
    logic [3:0]            reg_addr;
    logic [7:0]            reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [7:0]            reg_rdata;
    logic                  zero_comparator_out;
    ocd_pkg::amp_ctrl_type amp_ctrl;
    ocd_pkg::dac_ctrl_type dac_ctrl;
    logic                  comparator_one_pos_source;
    logic [3:0]            comparator_on;
    logic [3:0]            comparator_hysteresis_on;
    logic                  prot_trigger;
    logic                  irq;
    integer                err_total;
    integer                num_checks;
    integer                seed;
    integer                prot_cnt;
    integer                i;
    integer                n;
    logic [3:0]            a;
    logic [7:0]            d;
    logic                  exp_ev;
    logic [7:0]            shadow [0:3];

    overcurrent_detect_ctrl dut (
        .clock                     (clock),
        .sys_rst                   (sys_rst),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_wr                    (reg_wr),
        .reg_rd                    (reg_rd),
        .reg_rdata                 (reg_rdata),
        .zero_comparator_out       (zero_comparator_out),
        .amp_ctrl                  (amp_ctrl),
        .dac_ctrl                  (dac_ctrl),
        .comparator_one_pos_source (comparator_one_pos_source),
        .comparator_on             (comparator_on),
        .comparator_hysteresis_on  (comparator_hysteresis_on),
        .prot_trigger              (prot_trigger),
        .irq                       (irq)
    );

    always #2.5 clock = ~clock;

    // counts protection pulses, each stands one cycle
    always @(posedge clock) begin
        if (prot_trigger === 1'b1) begin
            prot_cnt <= prot_cnt + 1;
        end
    end

    // ==========================================
    // expectations
    function automatic logic [7:0] wmask(input logic [3:0] ad);
        case (ad)
            `OCD_ADDR_MODE: wmask = 8'he7;
            `OCD_ADDR_CAL:  wmask = 8'hdf;
            default:        wmask = 8'hff;
        endcase
    endfunction : wmask

    function automatic logic [28:0] exp_ctl();
        logic [7:0] m;
        logic [7:0] c;
        logic [7:0] p;
        logic       on0;
        m = shadow[0];
        c = shadow[2];
        p = shadow[3];
        on0 = (m[7:6] != 2'h0);
        exp_ctl = {m[2:0], m[2:0] != 3'h0, c[6], c[7], c[4:0], on0, shadow[1], m[5],
                   p[3:1], p[0] & on0, p[7:4]};
    endfunction : exp_ctl

    // ==========================================
    // compares
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk29(input logic [28:0] got, input logic [28:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t controls %h expected %h", $time, got, exp);
        end
    endtask : chk29

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t irq %b expected %b", $time, got, exp);
        end
    endtask : chk1

    // ==========================================
    // bus and stimulus
    task automatic settle();
        @(posedge clock);
        #1;
    endtask : settle

    task automatic wr(input logic [3:0] ad, input logic [7:0] wd);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= wd;
        @(posedge clock);
        reg_wr <= 1'b0;
        if (ad < 4'h4) begin
            shadow[ad[1:0]] = wd & wmask(ad);
        end
    endtask : wr

    task automatic rd_chk(input logic [3:0] ad, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp);
    endtask : rd_chk

    task automatic chk_ctl();
        settle();
        chk29({amp_ctrl, dac_ctrl, comparator_one_pos_source, comparator_on,
               comparator_hysteresis_on}, exp_ctl());
    endtask : chk_ctl

    task automatic comp_drive(input logic v);
        @(posedge clock);
        zero_comparator_out <= v;
        repeat (6) @(posedge clock);
    endtask : comp_drive

    task automatic do_reset();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        shadow[0] = 8'hc2;
        shadow[1] = 8'h00;
        shadow[2] = 8'h10;
        shadow[3] = 8'hf0;
    endtask : do_reset

    task automatic check_all();
        for (int k = 0; k < 4; k++) begin
            rd_chk(k[3:0], shadow[k]);
        end
        rd_chk(`OCD_ADDR_IRQ_STAT, 8'h00);
        rd_chk(`OCD_ADDR_IRQ_MASK, 8'h00);
        rd_chk(4'h9, 8'h00);
        chk_ctl();
    endtask : check_all

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // ==========================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("MISMATCH t=%0t run did not finish", $time);
        wrap_up();
    end

    // ==========================================
    // main sequence
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        zero_comparator_out = 1'b0;
        err_total = 0;
        num_checks = 0;
        prot_cnt = 0;
        seed = 33;
        do_reset();
        check_all();
        // mode programmed before the threshold code
        wr(`OCD_ADDR_MODE, 8'h42);
        wr(`OCD_ADDR_THRESH, 8'h80);
        chk_ctl();
        for (i = 0; i < 8; i++) begin
            wr(`OCD_ADDR_MODE, {5'h08, i[2:0]});
            chk_ctl();
        end
        // random traffic with unmapped places and all-ones/all-zeros corners
        for (n = 0; n < 60; n++) begin
            a = 4'($random(seed));
            if (a == 4'h4 || a == 4'h5) begin
                a = a + 4'h4;
            end
            d = (n % 8 == 0) ? 8'hff : (n % 8 == 1) ? 8'h00 : 8'($random(seed));
            wr(a, d);
            rd_chk(a, (a < 4'h4) ? shadow[a[1:0]] : 8'h00);
            chk_ctl();
        end
        // every edge mode, one rising and one falling edge each
        for (i = 0; i < 4; i++) begin
            wr(`OCD_ADDR_MODE, {i[1:0], 6'h02});
            wr(`OCD_ADDR_IRQ_MASK, 8'h03);
            wr(`OCD_ADDR_IRQ_STAT, 8'h03);
            prot_cnt = 0;
            comp_drive(1'b1);
            comp_drive(1'b0);
            exp_ev = (i == 1 || i == 2);
            rd_chk(`OCD_ADDR_IRQ_STAT, {6'h00, exp_ev, i != 0});
            chk8(prot_cnt[7:0], {7'h00, exp_ev});
            chk1(irq, i != 0);
        end
        // mask and clear of the sticky edge event
        wr(`OCD_ADDR_IRQ_MASK, 8'h00);
        settle();
        chk1(irq, 1'b0);
        wr(`OCD_ADDR_IRQ_MASK, 8'h01);
        settle();
        chk1(irq, 1'b1);
        wr(`OCD_ADDR_IRQ_STAT, 8'h01);
        settle();
        chk1(irq, 1'b0);
        rd_chk(`OCD_ADDR_IRQ_STAT, 8'h00);
        // clear strobe in the very cycle a dual-edge rise sets the flag: set wins
        @(posedge clock);
        zero_comparator_out <= 1'b1;
        repeat (2) @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= `OCD_ADDR_IRQ_STAT;
        reg_wdata <= 8'h01;
        @(posedge clock);
        reg_wr <= 1'b0;
        rd_chk(`OCD_ADDR_IRQ_STAT, 8'h01);
        chk1(irq, 1'b1);
        // pin back to idle so no edge follows the reset
        comp_drive(1'b0);
        // second reset in mid-run
        wr(`OCD_ADDR_CAL, 8'hff);
        do_reset();
        check_all();
        wrap_up();
    end

endmodule : overcurrent_detect_ctrl_bench
